// file: design/uefr_consts.svh
// offsets, field positions, reset values and timing counts of the event flags
`ifndef UEFR_CONSTS_SVH
`define UEFR_CONSTS_SVH
`define UEFR_OFS_FLAGS       12'h000
`define UEFR_OFS_MASK        12'h004
`define UEFR_OFS_CTRL        12'h008
`define UEFR_OFS_ERRMASK     12'h00C
`define UEFR_BIT_STALL       7
`define UEFR_BIT_ATTACH      6
`define UEFR_BIT_RESUME      5
`define UEFR_BIT_IDLE        4
`define UEFR_BIT_TOKEN       3
`define UEFR_BIT_SOF         2
`define UEFR_BIT_ERR         1
`define UEFR_BIT_RSTDET      0
`define UEFR_FLAGS_RESET     8'h00
`define UEFR_CLK_MHZ         50
`define UEFR_ATTACH_NS       2500
`define UEFR_RESUME_NS       2500
`define UEFR_IDLE_US         3000
`define UEFR_ATTACH_CYC      ((`UEFR_ATTACH_NS * `UEFR_CLK_MHZ + 999) / 1000)
`define UEFR_RESUME_CYC      ((`UEFR_RESUME_NS * `UEFR_CLK_MHZ + 999) / 1000)
`define UEFR_IDLE_CYC        (`UEFR_IDLE_US * `UEFR_CLK_MHZ)
`endif

// file: design/uefr_pkg.sv
// types of the usb event flag register block
package uefr_pkg;
    // event pulses reported by the usb engine, one cycle each
    typedef struct packed {
        logic stall_rx;
        logic stall_tx;
        logic sof_rx;
        logic sof_threshold;
        logic token_done;
        logic bus_reset;
        logic detach;
    } uefr_events_s;
    // line state from the transceiver, not synchronous to hclk
    typedef struct packed {
        logic bus_active;
        logic se0;
        logic k_state;
        logic idle_state;
    } uefr_line_s;
    typedef enum logic [1:0] {
        UEFR_IDLE_PH,
        UEFR_DATA_WR,
        UEFR_DATA_RD
    } uefr_phase_e;
endpackage

// file: design/uefr_top.sv
// usb event flag register with ahb-lite slave, mask and interrupt
//
// Notes on behaviour
// R1: stall flag bit 7: host receives stall, device transmits stall.
// R2: attach flag needs host role, 2.5 us without activity, no SE0.
// R3: resume flag set when K-state holds for 2.5 us.
// R4: software keeps resume masked unless the controller is suspended.
// R5: idle flag set after bus idle continuously for 3 ms.
// R6: token done flag set when token processing finishes; status fifo informs.
// R7: clearing the token done flag advances the token status fifo.
// R8: sof flag: device receives sof token, host reaches sof threshold.
// R9: error summary set only by errors enabled in error enable mask.
// R10: device mode bit 0 is bus reset flag.
// R11: host mode bit 0 is detach flag.
// R12: flags reset to zero, set by hardware, cleared by writing one.
// R13: bits 31 to 8 read as zero.
// R14: flags stay set until cleared; set wins over same-cycle clear.
// R15: host role enable picks host or device event sources.
`timescale 1ns/1ps
`include "uefr_consts.svh"

module uefr_top #(
    parameter int unsigned IDLE_CYC   = `UEFR_IDLE_CYC,
    parameter int unsigned ATTACH_CYC = `UEFR_ATTACH_CYC,
    parameter int unsigned RESUME_CYC = `UEFR_RESUME_CYC
) (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  clk_en,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire uefr_pkg::uefr_events_s usb_events,
    input  wire logic [7:0]            usb_errors,
    input  wire uefr_pkg::uefr_line_s  line_pins,
    output logic                       token_fifo_advance,
    output logic                       host_role_enable,
    output logic                       usb_irq
);
    import uefr_pkg::*;

    localparam logic [31:0] IDLE_N   = 32'(IDLE_CYC);
    localparam logic [31:0] ATTACH_N = 32'(ATTACH_CYC);
    localparam logic [31:0] RESUME_N = 32'(RESUME_CYC);

    uefr_line_s  line_s1_ff;
    uefr_line_s  line_s2_ff;
    logic [7:0]  usb_event_flags_ff;
    logic [7:0]  irq_mask_ff;
    logic [7:0]  error_enable_mask_ff;
    logic        host_role_ff;
    logic [31:0] idle_cnt_ff;
    logic [31:0] quiet_cnt_ff;
    logic [31:0] kstate_cnt_ff;
    logic        idle_hit_ff;
    logic        quiet_hit_ff;
    logic        kstate_hit_ff;
    uefr_phase_e phase_ff;
    logic [11:0] addr_ff;
    logic        fifo_adv_ff;
    logic        irq_ff;
    logic [31:0] rdata_ff;

    logic        ahb_start;
    logic        wr_flags;
    logic [7:0]  clr_bits;
    logic [7:0]  set_bits;
    logic [7:0]  nxt_flags;
    logic        attach_ev;
    logic        idle_ev;
    logic        resume_ev;

    // line pins are asynchronous: two stages before any use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_s1_ff <= '0;
            line_s2_ff <= '0;
        end else if (clk_en) begin
            line_s1_ff <= line_pins;
            line_s2_ff <= line_s1_ff;
        end
    end

    // continuous idle timer, fires once per idle stretch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_cnt_ff <= 32'h00000000;
            idle_hit_ff <= 1'b0;
        end else if (clk_en) begin
            if (!line_s2_ff.idle_state) begin
                idle_cnt_ff <= 32'h00000000;
                idle_hit_ff <= 1'b0;
            end else if (idle_cnt_ff < IDLE_N) begin
                idle_cnt_ff <= idle_cnt_ff + 32'h00000001;
            end else begin
                idle_hit_ff <= 1'b1;
            end
        end
    end
    assign idle_ev = line_s2_ff.idle_state && (idle_cnt_ff >= IDLE_N)
                     && !idle_hit_ff;                                // [R5]

    // quiet bus timer for attach detection, host role only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet_cnt_ff <= 32'h00000000;
            quiet_hit_ff <= 1'b0;
        end else if (clk_en) begin
            if (line_s2_ff.bus_active || line_s2_ff.se0 || !host_role_ff) begin
                quiet_cnt_ff <= 32'h00000000;
                quiet_hit_ff <= 1'b0;
            end else if (quiet_cnt_ff < ATTACH_N) begin
                quiet_cnt_ff <= quiet_cnt_ff + 32'h00000001;
            end else begin
                quiet_hit_ff <= 1'b1;
            end
        end
    end
    assign attach_ev = host_role_ff && !line_s2_ff.bus_active
                       && !line_s2_ff.se0 && (quiet_cnt_ff >= ATTACH_N)
                       && !quiet_hit_ff;                             // [R2]

    // k-state persistence timer for resume
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            kstate_cnt_ff <= 32'h00000000;
            kstate_hit_ff <= 1'b0;
        end else if (clk_en) begin
            if (!line_s2_ff.k_state) begin
                kstate_cnt_ff <= 32'h00000000;
                kstate_hit_ff <= 1'b0;
            end else if (kstate_cnt_ff < RESUME_N) begin
                kstate_cnt_ff <= kstate_cnt_ff + 32'h00000001;
            end else begin
                kstate_hit_ff <= 1'b1;
            end
        end
    end
    assign resume_ev = line_s2_ff.k_state && (kstate_cnt_ff >= RESUME_N)
                       && !kstate_hit_ff;                            // [R3]

    // hardware set sources; stall, sof and bit 0 selected by role
    always_comb begin
        set_bits = 8'h00;
        set_bits[`UEFR_BIT_STALL] = host_role_ff ? usb_events.stall_rx
                                                 : usb_events.stall_tx; // [R1] [R15]
        set_bits[`UEFR_BIT_ATTACH] = attach_ev;                      // [R2]
        set_bits[`UEFR_BIT_RESUME] = resume_ev;                      // [R3]
        set_bits[`UEFR_BIT_IDLE]   = idle_ev;                        // [R5]
        set_bits[`UEFR_BIT_TOKEN]  = usb_events.token_done;          // [R6]
        set_bits[`UEFR_BIT_SOF] = host_role_ff ? usb_events.sof_threshold
                                               : usb_events.sof_rx;  // [R8] [R15]
        set_bits[`UEFR_BIT_ERR] = |(usb_errors & error_enable_mask_ff); // [R9]
        set_bits[`UEFR_BIT_RSTDET] = host_role_ff ? usb_events.detach  // [R11]
                                                  : usb_events.bus_reset; // [R10]
    end

    // ahb-lite slave: one wait-free data phase
    assign ahb_start = hsel && hready && htrans[1];
    assign wr_flags  = (phase_ff == UEFR_DATA_WR)
                       && (addr_ff == `UEFR_OFS_FLAGS);
    assign clr_bits  = wr_flags ? hwdata[7:0] : 8'h00;               // [R12]
    assign nxt_flags = (usb_event_flags_ff & ~clr_bits) | set_bits;  // [R14]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_ff <= UEFR_IDLE_PH;
            addr_ff  <= 12'h000;
        end else if (clk_en) begin
            if (ahb_start) begin
                phase_ff <= hwrite ? UEFR_DATA_WR : UEFR_DATA_RD;
                addr_ff  <= {haddr[11:2], 2'b00};
            end else begin
                phase_ff <= UEFR_IDLE_PH;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            usb_event_flags_ff <= `UEFR_FLAGS_RESET;                 // [R12]
        end else if (clk_en) begin
            usb_event_flags_ff <= nxt_flags;                         // [R14]
        end
    end

    // software control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_ff          <= 8'h00;
            error_enable_mask_ff <= 8'h00;
            host_role_ff         <= 1'b0;
        end else if (clk_en && phase_ff == UEFR_DATA_WR) begin
            case (addr_ff)
                `UEFR_OFS_MASK:    irq_mask_ff <= hwdata[7:0];
                `UEFR_OFS_CTRL:    host_role_ff <= hwdata[0];        // [R15]
                `UEFR_OFS_ERRMASK: error_enable_mask_ff <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    // token fifo advance: pulse when software clears a set token flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fifo_adv_ff <= 1'b0;
        end else if (clk_en) begin
            fifo_adv_ff <= clr_bits[`UEFR_BIT_TOKEN]
                           && usb_event_flags_ff[`UEFR_BIT_TOKEN];   // [R7]
        end
    end

    // read data registered at the address phase, upper bits zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_ff <= 32'h00000000;
        end else if (clk_en) begin
            rdata_ff <= 32'h00000000;
            if (ahb_start && !hwrite) begin
                case ({haddr[11:2], 2'b00})
                    `UEFR_OFS_FLAGS:
                        rdata_ff <= {24'h000000, nxt_flags};         // [R13]
                    `UEFR_OFS_MASK:
                        rdata_ff <= {24'h000000, irq_mask_ff};
                    `UEFR_OFS_CTRL:
                        rdata_ff <= {31'h00000000, host_role_ff};
                    `UEFR_OFS_ERRMASK:
                        rdata_ff <= {24'h000000, error_enable_mask_ff};
                    default:
                        rdata_ff <= 32'h00000000;
                endcase
            end
        end
    end

    // level interrupt; software keeps resume masked unless suspended [R4]
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_ff <= 1'b0;
        end else if (clk_en) begin
            irq_ff <= |(nxt_flags & irq_mask_ff);
        end
    end

    assign hrdata             = rdata_ff;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign token_fifo_advance = fifo_adv_ff;
    assign host_role_enable   = host_role_ff;
    assign usb_irq            = irq_ff;

    logic unused_ok;
    assign unused_ok = ^{haddr[31:12], haddr[1:0], hsize, hwdata[31:8]};
endmodule

// file: dv/uefr_monitor.sv
// checker of the usb event flag block, bound to its top module
`timescale 1ns/1ps
module uefr_monitor (
    input wire logic                   hclk,
    input wire logic                   hresetn,
    input wire logic                   hsel,
    input wire logic [31:0]            haddr,
    input wire logic [1:0]             htrans,
    input wire logic                   hwrite,
    input wire logic [31:0]            hwdata,
    input wire logic [31:0]            hrdata,
    input wire uefr_pkg::uefr_events_s usb_events,
    input wire logic                   token_fifo_advance,
    input wire logic                   host_role_enable,
    input wire logic                   usb_irq
);
    import uefr_pkg::*;
    logic       fw_ff, mw_ff;
    logic [7:0] mask_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fw_ff   <= 1'b0;
            mw_ff   <= 1'b0;
            mask_ff <= 8'h00;
        end else begin
            fw_ff <= hsel && htrans[1] && hwrite && haddr[11:2] == 10'h000;
            mw_ff <= hsel && htrans[1] && hwrite && haddr[11:2] == 10'h001;
            if (mw_ff)
                mask_ff <= hwdata[7:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property ev_irq(logic role, logic ev, logic m);
        role && ev && m |=> usb_irq;
    endproperty
    upper_zero_a: assert property (hrdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    fifo_adv_a: assert property (token_fifo_advance |->
        $past(fw_ff && hwdata[3])) else $error("stray fifo advance");
    stall_host_a: assert property (ev_irq(host_role_enable,
        usb_events.stall_rx, mask_ff[7])) else $error("host stall lost");
    stall_dev_a: assert property (ev_irq(!host_role_enable,
        usb_events.stall_tx, mask_ff[7])) else $error("device stall lost");
    sof_dev_a: assert property (ev_irq(!host_role_enable,
        usb_events.sof_rx, mask_ff[2])) else $error("frame start lost");
    bus_reset_a: assert property (ev_irq(!host_role_enable,
        usb_events.bus_reset, mask_ff[0])) else $error("bus reset lost");
    detach_a: assert property (ev_irq(host_role_enable,
        usb_events.detach, mask_ff[0])) else $error("detach lost");
    irq_hold_a: assert property (usb_irq && !(fw_ff || mw_ff) &&
        !$past(fw_ff || mw_ff) && !$past(fw_ff || mw_ff, 2) |=> usb_irq)
        else $error("interrupt dropped");
    fifo_c: cover property (token_fifo_advance);
    irq_c: cover property ($fell(usb_irq));
    host_c: cover property (host_role_enable && usb_irq);
endmodule

bind uefr_top uefr_monitor i_mon (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hrdata(hrdata), .usb_events(usb_events),
    .token_fifo_advance(token_fifo_advance),
    .host_role_enable(host_role_enable), .usb_irq(usb_irq));

// file: dv/uefr_top_tb.sv
// self-checking bench of the usb event flag block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    n_fail++; $display("Error %s exp %h got %h", nm, e, g); end end
module uefr_top_tb;
    import uefr_pkg::*;
    logic         hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, rd_dp = 1'b0;
    logic         hrdy, hresp, adv, host, irq;
    logic         clk_en = 1'b1, hsel = 1'b1;
    logic [1:0]   htrans = 2'h0;
    logic [31:0]  haddr = '0, hwdata = '0, hrdata, exp_v, exp_q[$];
    logic [7:0]   err_cmd = '0, usb_errors, m, e;
    uefr_events_s ev_cmd = '0, usb_events;
    uefr_line_s   line_cmd = 4'h8, line_pins;
    int           n_fail = 0, num_checks = 0, seed = 32'h5B9F;
    logic [7:0]   dev_t[7] = '{8'h00, 8'h01, 8'h08, 8'h00, 8'h04, 8'h80, 8'h00};
    logic [7:0]   hst_t[7] = '{8'h01, 8'h00, 8'h08, 8'h04, 8'h00, 8'h00, 8'h80};
    logic [7:0]   lex_t[6] = '{8'h00, 8'h40, 8'h00, 8'h10, 8'h00, 8'h20};
    logic [3:0]   ln_t[6] = '{4'h4, 4'h0, 4'h9, 4'h9, 4'hA, 4'hA};
    int           len_t[6] = '{12, 12, 12, 30, 3, 9};
    always #10 hclk = ~hclk;
    uefr_top #(.IDLE_CYC(20), .ATTACH_CYC(5), .RESUME_CYC(5)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
        .hresp(hresp), .usb_events(usb_events), .usb_errors(usb_errors),
        .line_pins(line_pins), .token_fifo_advance(adv),
        .host_role_enable(host), .usb_irq(irq));
    uefr_usb_peer i_peer (.hclk(hclk), .ev_cmd(ev_cmd), .err_cmd(err_cmd),
        .line_cmd(line_cmd), .usb_events(usb_events),
        .usb_errors(usb_errors), .line_pins(line_pins));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wait_rdy();
        for (int n = 0; n < 20; n++) begin
            @(posedge hclk);
            if (hrdy === 1'b1)
                return;
        end
        n_fail++;
        tally_and_finish();
    endtask
    task automatic bus(input logic [11:0] a, input logic w,
                       input logic [31:0] d, input uefr_events_s ev = '0);
        @(posedge hclk);
        haddr  <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        ev_cmd <= ev;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        ev_cmd <= '0;
        if (!w)
            exp_q.push_back(d);
        wait_rdy();
    endtask
    // hold engine, error and line requests for n cycles, then let sync settle
    task automatic poke(input uefr_events_s ev, input logic [7:0] er,
                        input uefr_line_s l, input int n);
        @(posedge hclk);
        ev_cmd   <= ev;
        err_cmd  <= er;
        line_cmd <= l;
        repeat (n) @(posedge hclk);
        ev_cmd   <= '0;
        err_cmd  <= 8'h00;
        line_cmd <= 4'h8;
        repeat (4) @(posedge hclk);
    endtask
    always @(posedge hclk) begin
        if (rd_dp) begin
            exp_v = exp_q.pop_front();
            `CHK("read data", exp_v, hrdata)
        end
        rd_dp <= htrans[1] && !hwrite && hresetn;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        for (int a = 0; a < 20; a += 4)
            bus(12'(a), 1'b0, 32'h0);
        bus(12'h004, 1'b1, 32'hFFFFFFFF);
        bus(12'h004, 1'b0, 32'h000000FF);
        for (int h = 0; h < 2; h++) begin
            bus(12'h008, 1'b1, h);
            for (int i = 0; i < 7; i++) begin
                poke(7'h01 << i, 8'h00, 4'h8, 1);
                bus(12'h000, 1'b0, h ? hst_t[i] : dev_t[i]);
                bus(12'h000, 1'b1, 32'h0);
                bus(12'h000, 1'b0, h ? hst_t[i] : dev_t[i]);
                bus(12'h000, 1'b1, 32'hFF);
                bus(12'h000, 1'b0, 32'h0);
            end
            `CHK("host role", 1'(h), host)
        end
        poke(7'h40, 8'h00, 4'h8, 1);
        `CHK("irq on", 1'b1, irq)
        bus(12'h004, 1'b1, 32'h0);
        repeat (2) @(posedge hclk);
        `CHK("irq masked", 1'b0, irq)
        bus(12'h000, 1'b0, 32'h80);
        bus(12'h004, 1'b1, 32'hDF);
        bus(12'h000, 1'b1, 32'hFF, 7'h04);
        bus(12'h000, 1'b0, 32'h08);
        bus(12'h000, 1'b1, 32'h08);
        bus(12'h000, 1'b0, 32'h0);
        repeat (2) @(posedge hclk);
        `CHK("irq clear", 1'b0, irq)
        for (int i = 0; i < 4; i++) begin
            m = $random(seed);
            e = i ? 8'($random(seed)) : ~m;
            bus(12'h00C, 1'b1, m);
            bus(12'h00C, 1'b0, m);
            poke('0, e, 4'h8, 1);
            bus(12'h000, 1'b0, |(m & e) ? 32'h2 : 32'h0);
            bus(12'h000, 1'b1, 32'hFF);
        end
        for (int k = 0; k < 6; k++) begin
            if (k == 2)
                bus(12'h008, 1'b1, 32'h0);
            poke('0, 8'h00, ln_t[k], len_t[k]);
            bus(12'h000, 1'b0, lex_t[k]);
            bus(12'h000, 1'b1, 32'hFF);
        end
        // a sof threshold pulse under a frozen clock enable, in device role, must leave the flags clear
        clk_en <= 1'b0;
        poke(7'h08, 8'h00, 4'h8, 1);
        clk_en <= 1'b1;
        bus(12'h000, 1'b0, 32'h0);
        // a deselected write must leave the mask alone
        hsel <= 1'b0;
        bus(12'h004, 1'b1, 32'h0);
        hsel <= 1'b1;
        bus(12'h004, 1'b0, 32'hDF);
        tally_and_finish();
    end
endmodule

// file: dv/uefr_usb_peer.sv
// usb engine and line model on the event side of the flag block
`timescale 1ns/1ps
module uefr_usb_peer (
    input  wire logic                   hclk,
    input  wire uefr_pkg::uefr_events_s ev_cmd,
    input  wire logic [7:0]             err_cmd,
    input  wire uefr_pkg::uefr_line_s   line_cmd,
    output uefr_pkg::uefr_events_s      usb_events,
    output logic [7:0]                  usb_errors,
    output uefr_pkg::uefr_line_s        line_pins
);
    import uefr_pkg::*;
    initial {usb_events, usb_errors, line_pins} = {15'h0, 4'h8};
    // engine reports come as hclk pulses one cycle after the request
    always @(posedge hclk) begin
        usb_events <= ev_cmd;
        usb_errors <= err_cmd;
    end
    // line levels move with no relation to hclk
    always @(line_cmd) line_pins <= #7 line_cmd;
endmodule
